// >>> core/aia_alloc.sv
`timescale 1ns/1ps

// Functional notes
// - Both modes may hold same scaling format.
// - Four setpoints stay separately selectable always.
// - Display and speed formats combine freely.
// - Codes 0-3: unused, ext ref, feedback, aux.
// - Codes 4-7 replace setpoints one to four.
// - Replaced input forces PULSES_PER_REV 60, max 4095.
// - Code 1 forces ext ref PULSES_PER_REV and maxima.
// - Full-scale count equals 4095 Hz input rate.
// - Code 2 forces feedback PULSES_PER_REV and maxima.
// - Forced parameters ignore operator writes.
// - Converter gives 4095 at 10 volts.
module aia_alloc
	import aia_pkg::*;
#(
	parameter int PARAM_W = 16,
	parameter int FREQ_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Analog converter count and measured pulse rates
	input wire logic [ADC_W-1:0] analog_count_i,
	input wire logic [FREQ_W-1:0] ext_ref_freq_i,
	input wire logic [FREQ_W-1:0] feedback_freq_i,
	input wire logic [FREQ_W-1:0] aux_freq_i,
	// Values handed to the speed calculation
	output logic [FREQ_W-1:0] ext_ref_freq_o,
	output logic [FREQ_W-1:0] feedback_freq_o,
	output logic [FREQ_W-1:0] aux_freq_o,
	output logic [PARAM_W-1:0] setpoint_one_o,
	output logic [PARAM_W-1:0] setpoint_two_o,
	output logic [PARAM_W-1:0] setpoint_three_o,
	output logic [PARAM_W-1:0] setpoint_four_o,
	output logic [PARAM_W-1:0] primary_scaling_format_o,
	output logic [PARAM_W-1:0] secondary_scaling_format_o,
	output logic [PARAM_W-1:0] primary_display_format_o,
	output logic [PARAM_W-1:0] secondary_display_format_o,
	output logic [PARAM_W-1:0] ext_ref_pulses_per_rev_o,
	output logic [PARAM_W-1:0] feedback_pulses_per_rev_o,
	output logic [PARAM_W-1:0] aux_pulses_per_rev_o,
	output logic [PARAM_W-1:0] primary_ext_ref_max_rpm_o,
	output logic [PARAM_W-1:0] secondary_ext_ref_max_rpm_o,
	output logic [PARAM_W-1:0] primary_feedback_max_rpm_o,
	output logic [PARAM_W-1:0] secondary_feedback_max_rpm_o,
	output logic [PARAM_W-1:0] primary_aux_max_rpm_o,
	output logic [PARAM_W-1:0] secondary_aux_max_rpm_o,
	output logic [SEL_W-1:0] analog_function_select_o
);

	// ==================================================================
	// Elaboration checks
	// ==================================================================
	if (PARAM_W != 16) begin : g_bad_param_w
		$error("PARAM_W must be 16.");
	end
	if ((FREQ_W <= ADC_W) || (FREQ_W > 32)) begin : g_bad_freq_w
		$error("FREQ_W must lie between 13 and 32.");
	end
	if (IDX_STATUS >= (1 << IDX_W)) begin : g_bad_idx_w
		$error("IDX_W is too narrow for the register map.");
	end

	// ==================================================================
	// Bus address and data phases
	// ==================================================================
	aia_bus_state_type state_q;
	aia_bus_state_type state_d;
	logic [IDX_W-1:0] idx_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic [IDX_W-1:0] addr_idx;
	logic accept;
	logic accept_wr;
	logic accept_rd;
	logic wr_phase;
	logic [31:0] rd_word;
	logic idx_is_param;
	logic idx_is_status;

	assign addr_idx = haddr_i[IDX_LSB +: IDX_W];
	assign accept = hsel_i && htrans_i[1] && hready_i;
	assign accept_wr = accept && hwrite_i;
	assign accept_rd = accept && !hwrite_i;
	assign wr_phase = (state_q == BUS_WRITE);

	always_comb begin
		state_d = BUS_IDLE;
		case (state_q)
			BUS_IDLE,
			BUS_WRITE: begin
				if (accept_wr) begin
					state_d = BUS_WRITE;
				end else if (accept_rd) begin
					state_d = BUS_READ;
				end else begin
					state_d = BUS_IDLE;
				end
			end
			BUS_READ: begin
				state_d = BUS_IDLE;
			end
			default: begin
				state_d = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= BUS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// The accepted address is kept for the data phase that follows.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_q <= '0;
		end else if (accept) begin
			idx_q <= addr_idx;
		end
	end

	// Reads take one wait state so that a write just before is visible.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= (state_d != BUS_READ);
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hrdata_q <= '0;
		end else if (state_q == BUS_READ) begin
			hrdata_q <= rd_word;
		end
	end

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hreadyout_q;
	// Every transfer is answered OKAY; refused writes are simply dropped.
	assign hresp_o = 1'b0;

	// ==================================================================
	// Parameter store
	// ==================================================================
	logic [PARAM_W-1:0] param_val [NUM_PARAMS];
	logic [NUM_PARAMS-1:0] lock_vec;
	logic [SEL_W-1:0] sel;

	assign sel = param_val[IDX_ANALOG_SEL][SEL_W-1:0];

	// A forced constant stays in place after the select code moves on,
	// until the operator writes that parameter again.
	// Every format, constant and setpoint has storage of its own.
	for (genvar i = 0; i < NUM_PARAMS; i++) begin : g_param
		logic wr_en;
		assign wr_en = wr_phase && (idx_q == IDX_W'(i));
		assign lock_vec[i] = aia_locked(i, sel);
		aia_param_reg #(
			.WIDTH(PARAM_W),
			.RESET_VAL(PARAM_RESET),
			.FORCED_VAL(aia_forced(i))
		) u_param (
			.clk_sys_i(clk_sys_i),
			.resetn_i(resetn_i),
			.wr_en_i(wr_en),
			.wr_data_i(hwdata_i[PARAM_W-1:0]),
			.lock_i(lock_vec[i]),
			.value_o(param_val[i])
		);
	end

	// ==================================================================
	// Register read selection
	// ==================================================================
	logic [31:0] status_word;
	logic [31-STATUS_LOCK_LSB:0] lock_low;

	// Only the first sixteen lock bits fit above the count; the last two
	// slots hold setpoints, which never lock.
	assign lock_low = lock_vec[31-STATUS_LOCK_LSB:0];
	assign idx_is_param = (idx_q < IDX_W'(NUM_PARAMS));
	assign idx_is_status = (idx_q == IDX_W'(IDX_STATUS));
	assign status_word = {
		lock_low,
		{(STATUS_LOCK_LSB - ADC_W){1'b0}},
		analog_count_i
	};
	assign rd_word = idx_is_param ?
		{{(32-PARAM_W){1'b0}}, param_val[idx_q]} :
		(idx_is_status ? status_word : 32'h0000_0000);

	// ==================================================================
	// Analog substitution
	// ==================================================================
	logic use_ext_ref;
	logic use_feedback;
	logic use_aux;
	logic [NUM_SETPOINTS-1:0] use_setpoint;
	logic [PARAM_W-1:0] setpoint_val [NUM_SETPOINTS];

	// Full-scale count stands for a 4095 Hz pulse rate.
	assign use_ext_ref = (sel == SEL_EXT_REF);
	assign use_feedback = (sel == SEL_FEEDBACK);
	assign use_aux = (sel == SEL_AUX);

	aia_substitute #(
		.WIDTH(FREQ_W),
		.ADC_WIDTH(ADC_W)
	) u_sub_ext_ref (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.use_analog_i(use_ext_ref),
		.analog_i(analog_count_i),
		.normal_i(ext_ref_freq_i),
		.value_o(ext_ref_freq_o)
	);

	aia_substitute #(
		.WIDTH(FREQ_W),
		.ADC_WIDTH(ADC_W)
	) u_sub_feedback (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.use_analog_i(use_feedback),
		.analog_i(analog_count_i),
		.normal_i(feedback_freq_i),
		.value_o(feedback_freq_o)
	);

	aia_substitute #(
		.WIDTH(FREQ_W),
		.ADC_WIDTH(ADC_W)
	) u_sub_aux (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.use_analog_i(use_aux),
		.analog_i(analog_count_i),
		.normal_i(aux_freq_i),
		.value_o(aux_freq_o)
	);

	for (genvar s = 0; s < NUM_SETPOINTS; s++) begin : g_setpoint
		assign use_setpoint[s] =
			(sel == (SEL_SETPOINT_ONE + SEL_W'(s)));
		aia_substitute #(
			.WIDTH(PARAM_W),
			.ADC_WIDTH(ADC_W)
		) u_sub_setpoint (
			.clk_sys_i(clk_sys_i),
			.resetn_i(resetn_i),
			.use_analog_i(use_setpoint[s]),
			.analog_i(analog_count_i),
			.normal_i(param_val[IDX_SETPOINT_ONE + s]),
			.value_o(setpoint_val[s])
		);
	end

	assign setpoint_one_o = setpoint_val[0];
	assign setpoint_two_o = setpoint_val[1];
	assign setpoint_three_o = setpoint_val[2];
	assign setpoint_four_o = setpoint_val[3];

	// ==================================================================
	// Parameter outputs
	// ==================================================================
	assign primary_scaling_format_o = param_val[IDX_PRI_SCALE_FMT];
	assign secondary_scaling_format_o = param_val[IDX_SEC_SCALE_FMT];
	assign primary_display_format_o = param_val[IDX_PRI_DISP_FMT];
	assign secondary_display_format_o = param_val[IDX_SEC_DISP_FMT];
	assign ext_ref_pulses_per_rev_o = param_val[IDX_EXT_PPR];
	assign feedback_pulses_per_rev_o = param_val[IDX_FB_PPR];
	assign aux_pulses_per_rev_o = param_val[IDX_AUX_PPR];
	assign primary_ext_ref_max_rpm_o = param_val[IDX_PRI_EXT_MAX];
	assign secondary_ext_ref_max_rpm_o = param_val[IDX_SEC_EXT_MAX];
	assign primary_feedback_max_rpm_o = param_val[IDX_PRI_FB_MAX];
	assign secondary_feedback_max_rpm_o = param_val[IDX_SEC_FB_MAX];
	assign primary_aux_max_rpm_o = param_val[IDX_PRI_AUX_MAX];
	assign secondary_aux_max_rpm_o = param_val[IDX_SEC_AUX_MAX];
	assign analog_function_select_o = sel;

endmodule // aia_alloc

// >>> core/aia_param_reg.sv
`timescale 1ns/1ps

// ==================================================================
// One operator parameter with a lockable forced value
// ==================================================================
module aia_param_reg #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] FORCED_VAL = '0
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic wr_en_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic lock_i,
	output logic [WIDTH-1:0] value_o
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] value_d;

	// A locked parameter keeps its forced value and ignores writes.
	assign value_d = lock_i ? FORCED_VAL :
		(wr_en_i ? wr_data_i : value_q);

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_o = value_q;

endmodule // aia_param_reg

// >>> core/aia_pkg.sv
package aia_pkg;

	// ==================================================================
	// Register map, word indices and byte offsets
	// ==================================================================
	localparam logic [6:0] OFS_ANALOG_SEL = 7'h00;
	localparam int IDX_ANALOG_SEL = 0;
	localparam int IDX_PRI_SCALE_FMT = 1;
	localparam int IDX_SEC_SCALE_FMT = 2;
	localparam int IDX_PRI_DISP_FMT = 3;
	localparam int IDX_SEC_DISP_FMT = 4;
	localparam int IDX_EXT_PPR = 5;
	localparam int IDX_FB_PPR = 6;
	localparam int IDX_AUX_PPR = 7;
	localparam int IDX_PRI_EXT_MAX = 8;
	localparam int IDX_SEC_EXT_MAX = 9;
	localparam int IDX_PRI_FB_MAX = 10;
	localparam int IDX_SEC_FB_MAX = 11;
	localparam int IDX_PRI_AUX_MAX = 12;
	localparam int IDX_SEC_AUX_MAX = 13;
	localparam int IDX_SETPOINT_ONE = 14;
	localparam int NUM_SETPOINTS = 4;
	localparam int NUM_PARAMS = 18;
	localparam int IDX_STATUS = 18;
	localparam int IDX_W = 5;
	localparam int IDX_LSB = 2;

	// ==================================================================
	// Field layout and reset values
	// ==================================================================
	localparam int SEL_W = 3;
	localparam int ADC_W = 12;
	localparam logic [15:0] PARAM_RESET = 16'h0000;
	localparam int STATUS_LOCK_LSB = 16;

	// ==================================================================
	// Analog allocation codes and forced constants
	// ==================================================================
	localparam logic [SEL_W-1:0] SEL_UNUSED = 3'h0;
	localparam logic [SEL_W-1:0] SEL_EXT_REF = 3'h1;
	localparam logic [SEL_W-1:0] SEL_FEEDBACK = 3'h2;
	localparam logic [SEL_W-1:0] SEL_AUX = 3'h3;
	localparam logic [SEL_W-1:0] SEL_SETPOINT_ONE = 3'h4;
	localparam logic [15:0] PPR_FORCED = 16'h003C;
	localparam logic [15:0] MAX_RPM_FORCED = 16'h0FFF;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} aia_bus_state_type;

	// Locked parameters of a frequency input replaced by the analog count.
	function automatic logic aia_locked(input int idx,
		input logic [SEL_W-1:0] sel);
		logic r;
		r = 1'b0;
		case (sel)
			SEL_EXT_REF: r = (idx == IDX_EXT_PPR) ||
				(idx == IDX_PRI_EXT_MAX) || (idx == IDX_SEC_EXT_MAX);
			SEL_FEEDBACK: r = (idx == IDX_FB_PPR) ||
				(idx == IDX_PRI_FB_MAX) || (idx == IDX_SEC_FB_MAX);
			SEL_AUX: r = (idx == IDX_AUX_PPR) ||
				(idx == IDX_PRI_AUX_MAX) || (idx == IDX_SEC_AUX_MAX);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] aia_forced(input int idx);
		logic [15:0] v;
		v = MAX_RPM_FORCED;
		if ((idx >= IDX_EXT_PPR) && (idx <= IDX_AUX_PPR)) begin
			v = PPR_FORCED;
		end
		return v;
	endfunction

endpackage

// >>> core/aia_substitute.sv
`timescale 1ns/1ps

// ==================================================================
// Registered choice between a normal value and the analog count
// ==================================================================
module aia_substitute #(
	parameter int WIDTH = 16,
	parameter int ADC_WIDTH = 12
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic use_analog_i,
	input wire logic [ADC_WIDTH-1:0] analog_i,
	input wire logic [WIDTH-1:0] normal_i,
	output logic [WIDTH-1:0] value_o
);

	logic [WIDTH-1:0] value_q;
	logic [WIDTH-1:0] analog_ext;

	// The count is used unscaled, zero extended.
	assign analog_ext = {{(WIDTH-ADC_WIDTH){1'b0}}, analog_i};

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			value_q <= '0;
		end else begin
			value_q <= use_analog_i ? analog_ext : normal_i;
		end
	end

	assign value_o = value_q;

endmodule // aia_substitute

// >>> test/aia_alloc_bench.sv
`timescale 1ns/1ps

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
	$display("Error %0t: got %h want %h", $time, a, e); end end

module aia_alloc_bench
	import aia_pkg::*;
;
	logic clk_sys_i, resetn_i, hsel_i, hwrite_i, hready_i;
	logic hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, d;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i, analog_function_select_o;
	logic [11:0] analog_count_i;
	logic [15:0] ext_ref_freq_i, feedback_freq_i, aux_freq_i;
	logic [15:0] ext_ref_freq_o, feedback_freq_o, aux_freq_o;
	logic [15:0] setpoint_one_o, setpoint_two_o;
	logic [15:0] setpoint_three_o, setpoint_four_o;
	logic [15:0] primary_scaling_format_o, secondary_scaling_format_o;
	logic [15:0] primary_display_format_o, secondary_display_format_o;
	logic [15:0] ext_ref_pulses_per_rev_o, feedback_pulses_per_rev_o;
	logic [15:0] aux_pulses_per_rev_o;
	logic [15:0] primary_ext_ref_max_rpm_o, secondary_ext_ref_max_rpm_o;
	logic [15:0] primary_feedback_max_rpm_o, secondary_feedback_max_rpm_o;
	logic [15:0] primary_aux_max_rpm_o, secondary_aux_max_rpm_o;
	logic [63:0] sp_all, fmt_all;
	logic [15:0] want;
	int n_errors, comparisons, i, c;

	assign hready_i = hreadyout_o;
	assign sp_all = {setpoint_one_o, setpoint_two_o,
		setpoint_three_o, setpoint_four_o};
	assign fmt_all = {primary_scaling_format_o, secondary_scaling_format_o,
		primary_display_format_o, secondary_display_format_o};

	aia_alloc dut (.*);

	aia_operator op (
		.clk_sys_i(clk_sys_i),
		.hready_i(hready_i),
		.hrdata_i(hrdata_o),
		.hsel_o(hsel_i),
		.haddr_o(haddr_i),
		.htrans_o(htrans_i),
		.hwrite_o(hwrite_i),
		.hsize_o(hsize_i),
		.hwdata_o(hwdata_i)
	);

	task automatic close_out();
		$display("Comparisons %0d, errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		repeat (3000) @(posedge clk_sys_i);
		n_errors++;
		close_out();
	end

	// ==================================================================
	// Main sequence
	// ==================================================================
	initial begin
		resetn_i = 1'b0;
		analog_count_i = 12'h000;
		ext_ref_freq_i = 16'h1001;
		feedback_freq_i = 16'h2002;
		aux_freq_i = 16'h3003;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		for (i = 0; i < NUM_PARAMS; i++) begin
			op.rd(7'(i * 4), d);
			`CHK(d, 32'h0000_0000)
		end
		op.wr(7'h04, 16'h0002);
		op.wr(7'h08, 16'h0002);
		op.wr(7'h0C, 16'h0001);
		op.wr(7'h10, 16'h0002);
		for (i = 0; i < NUM_SETPOINTS; i++) begin
			op.wr(7'((IDX_SETPOINT_ONE + i) * 4), 16'(16'h0A00 + i));
		end
		@(posedge clk_sys_i);
		analog_count_i <= 12'hFFF;
		@(negedge clk_sys_i);
		`CHK(fmt_all[63:32], 32'h0002_0002)
		`CHK(fmt_all[31:0], 32'h0001_0002)
		`CHK(sp_all, 64'h0A00_0A01_0A02_0A03)
		for (c = 0; c < 8; c++) begin
			op.wr(7'h00, 16'(c));
			repeat (2) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			`CHK(ext_ref_freq_o, c == 1 ? 16'h0FFF : 16'h1001)
			`CHK(feedback_freq_o, c == 2 ? 16'h0FFF : 16'h2002)
			`CHK(aux_freq_o, c == 3 ? 16'h0FFF : 16'h3003)
			for (i = 0; i < 4; i++) begin
				want = (c == 4 + i) ? 16'h0FFF : 16'(16'h0A00 + i);
				`CHK(sp_all[63-16*i -: 16], want)
			end
			if (c >= 1 && c <= 3) begin
				op.wr(7'((IDX_EXT_PPR + c - 1) * 4), 16'h1234);
				op.rd(7'((IDX_EXT_PPR + c - 1) * 4), d);
				`CHK(d, 32'h0000_003C)
				op.wr(7'((IDX_PRI_EXT_MAX + 2 * c - 2) * 4), 16'h1234);
				op.rd(7'((IDX_PRI_EXT_MAX + 2 * c - 2) * 4), d);
				`CHK(d, 32'h0000_0FFF)
				op.rd(7'((IDX_SEC_EXT_MAX + 2 * c - 2) * 4), d);
				`CHK(d, 32'h0000_0FFF)
			end
		end
		`CHK(aux_pulses_per_rev_o, 16'h003C)
		`CHK(primary_aux_max_rpm_o, 16'h0FFF)
		`CHK(secondary_feedback_max_rpm_o, 16'h0FFF)
		op.rd(7'h48, d);
		`CHK(d, 32'h0000_0FFF)
		op.wr(7'h50, 16'hFFFF);
		op.rd(7'h50, d);
		`CHK(d, 32'h0000_0000)
		close_out();
	end
endmodule // aia_alloc_bench

// >>> test/aia_alloc_properties.sv
`timescale 1ns/1ps

module aia_alloc_properties
	import aia_pkg::*;
#(
	parameter int PARAM_W = 16,
	parameter int FREQ_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [ADC_W-1:0] analog_count_i,
	input wire logic [FREQ_W-1:0] ext_ref_freq_i,
	input wire logic [FREQ_W-1:0] ext_ref_freq_o,
	input wire logic [FREQ_W-1:0] feedback_freq_o,
	input wire logic [PARAM_W-1:0] setpoint_one_o,
	input wire logic [PARAM_W-1:0] setpoint_four_o,
	input wire logic [PARAM_W-1:0] ext_ref_pulses_per_rev_o,
	input wire logic [PARAM_W-1:0] primary_ext_ref_max_rpm_o,
	input wire logic [PARAM_W-1:0] secondary_ext_ref_max_rpm_o,
	input wire logic [PARAM_W-1:0] feedback_pulses_per_rev_o,
	input wire logic [PARAM_W-1:0] primary_feedback_max_rpm_o,
	input wire logic [PARAM_W-1:0] aux_pulses_per_rev_o,
	input wire logic [PARAM_W-1:0] secondary_aux_max_rpm_o,
	input wire logic [SEL_W-1:0] analog_function_select_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	wire logic [FREQ_W-1:0] ana_f = FREQ_W'(analog_count_i);
	wire logic [PARAM_W-1:0] ana_p = PARAM_W'(analog_count_i);
	wire logic taken = hsel_i && htrans_i[1] && hready_i;
	wire logic [SEL_W-1:0] sel = analog_function_select_o;
	sequence rd_taken;
		taken && !hwrite_i;
	endsequence
	sequence rd_answer;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	sequence held(logic [SEL_W-1:0] c);
		(sel == c) [*2];
	endsequence
	read_wait_a: assert property (rd_taken |=> rd_answer)
		else $error("Read data phase is not one wait state.");
	write_nowait_a: assert property (taken && hwrite_i |=> hreadyout_o)
		else $error("Write data phase stalled.");
	resp_okay_a: assert property (hresp_o == 1'b0)
		else $error("Response is not OKAY.");
	// An attempt on the release edge still sees the reset value.
	unused_pass_a: assert property (
		resetn_i && sel == SEL_UNUSED |=>
		ext_ref_freq_o == $past(ext_ref_freq_i))
		else $error("Measured rate not passed through.");
	ext_swap_a: assert property (
		sel == SEL_EXT_REF |=> ext_ref_freq_o == $past(ana_f))
		else $error("Analog count not on reference rate.");
	fb_swap_a: assert property (
		sel == SEL_FEEDBACK |=> feedback_freq_o == $past(ana_f))
		else $error("Analog count not on feedback rate.");
	sp_one_a: assert property (
		sel == SEL_SETPOINT_ONE |=> setpoint_one_o == $past(ana_p))
		else $error("Analog count not on setpoint one.");
	sp_four_a: assert property (
		sel == 3'h7 |=> setpoint_four_o == $past(ana_p))
		else $error("Analog count not on setpoint four.");
	ext_lock_a: assert property (held(SEL_EXT_REF) |->
		ext_ref_pulses_per_rev_o == PPR_FORCED &&
		primary_ext_ref_max_rpm_o == MAX_RPM_FORCED &&
		secondary_ext_ref_max_rpm_o == MAX_RPM_FORCED)
		else $error("Reference constants not forced.");
	fb_lock_a: assert property (held(SEL_FEEDBACK) |->
		feedback_pulses_per_rev_o == PPR_FORCED &&
		primary_feedback_max_rpm_o == MAX_RPM_FORCED)
		else $error("Feedback constants not forced.");
	aux_lock_a: assert property (held(SEL_AUX) |->
		aux_pulses_per_rev_o == PPR_FORCED &&
		secondary_aux_max_rpm_o == MAX_RPM_FORCED)
		else $error("Auxiliary constants not forced.");
endmodule // aia_alloc_properties

bind aia_alloc aia_alloc_properties #(
	.PARAM_W(PARAM_W),
	.FREQ_W(FREQ_W)
) u_props (.*);

// >>> test/aia_operator.sv
`timescale 1ns/1ps

// Operator model: single word transfers, one per call.
module aia_operator (
	input wire logic clk_sys_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o
);
	initial begin
		hsel_o = 1'b0;
		haddr_o = 32'h0000_0000;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0000_0000;
	end

	task automatic xfer(input logic w, input logic [6:0] a,
		input logic [15:0] wd, output logic [31:0] rd);
		@(posedge clk_sys_i);
		hsel_o <= 1'b1;
		haddr_o <= 32'(a);
		htrans_o <= 2'h2;
		hwrite_o <= w;
		@(posedge clk_sys_i iff hready_i);
		hsel_o <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= 32'(wd);
		@(posedge clk_sys_i iff hready_i);
		rd = hrdata_i;
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [31:0] unused;
		xfer(1'b1, a, d, unused);
	endtask

	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		xfer(1'b0, a, 16'h0000, d);
	endtask
endmodule // aia_operator
